// ### design/scps_pkg.sv
// constants for the strap capture and palette strobe block
package scps_pkg;
  // host i/o ports
  localparam logic [15:0] PORT_PEL_MASK = 16'h03C6;
  localparam logic [15:0] PORT_DAC_RD_ADDR = 16'h03C7;
  localparam logic [15:0] PORT_DAC_WR_ADDR = 16'h03C8;
  localparam logic [15:0] PORT_DAC_DATA = 16'h03C9;
  localparam logic [15:0] PORT_STATUS0 = 16'h03C2;
  localparam logic [15:0] PORT_CRT_DATA_MONO = 16'h03B5;
  localparam logic [15:0] PORT_CRT_DATA_COLOR = 16'h03D5;
  localparam logic [15:0] PORT_STATUS1_MONO = 16'h03BA;
  localparam logic [15:0] PORT_STATUS1_COLOR = 16'h03DA;
  // extension register indexes behind the index/data ports
  localparam logic [7:0] IDX_PANEL_SWITCH = 8'h2A;
  localparam logic [7:0] IDX_PANEL_SELECT = 8'h31;
  localparam logic [7:0] IDX_GENERAL_STRAP = 8'h0F;
  localparam logic [7:0] IDX_ROM_MAPPING = 8'h0B;
  // avalon byte offsets
  localparam logic [4:0] OFF_MISC_OUT = 5'h00;
  localparam logic [4:0] OFF_INPUT_STATUS0 = 5'h04;
  localparam logic [4:0] OFF_PANEL_SWITCH = 5'h08;
  localparam logic [4:0] OFF_GENERAL_STRAP = 5'h0C;
  localparam logic [4:0] OFF_PANEL_SELECT = 5'h10;
  localparam logic [4:0] OFF_ROM_MAPPING = 5'h14;
  localparam logic [4:0] OFF_MODE_CTRL = 5'h18;
  localparam logic [4:0] OFF_BLOCK_STATUS = 5'h1C;
  // field positions
  localparam int MISC_IO_SEL_BIT = 0;
  localparam int STATUS0_SENSE_BIT = 4;
  localparam int SWITCH_PANEL_TYPE_BIT = 7;
  localparam int MODE_LCD_BIT = 0;
  localparam int MODE_TFT_BIT = 1;
  localparam int BSTAT_EXT_DAC_BIT = 0;
  localparam int BSTAT_COLOR_IO_BIT = 1;
  localparam int BSTAT_CAPTURED_BIT = 2;
  // strap line positions
  localparam int MD_SWITCH_HI = 15;
  localparam int MD_SWITCH_LO = 12;
  localparam int MD_DISPLAY_TYPE = 11;
  localparam int MD_PANEL_SEL_HI = 9;
  localparam int MD_PANEL_SEL_LO = 8;
  localparam int MD_GENERAL_HI = 7;
  localparam int MD_GENERAL_LO = 4;
  localparam int MD_VCLK_DIR = 3;
  localparam int MD_BUS_MODE = 2;
  localparam int MD_ROM_HI = 1;
  localparam int MD_ROM_LO = 0;
  // reset values
  localparam logic [7:0] MISC_OUT_RESET = 8'h00;
  localparam logic [1:0] MODE_CTRL_RESET = 2'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // strap capture waits for both synchroniser stages to fill
  localparam logic [1:0] CAPTURE_DELAY = 2'h2;
endpackage

// ### design/scps_top.sv
// strap capture, palette strobes and dac mode logic with avalon registers
`timescale 1ns/1ps
module scps_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // host i/o cycle pins
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_n_i,
  input wire logic io_wr_n_i,
  // palette strobes
  output logic palette_read_strobe_n_o,
  output logic palette_write_strobe_n_o,
  input wire logic panel_video_bit9_i,
  // dac mode pins
  input wire logic vref_grounded_i,
  input wire logic monitor_sense_input_i,
  output logic internal_dac_enable_o,
  output logic display_type_select_out_o,
  // strap pins, direct strap outputs and the resolved crt data and status1 ports
  input wire logic [15:0] video_memory_data_lines_i,
  output logic secondary_video_clock_dir_o,
  output logic host_bus_mode_o,
  output logic [15:0] crt_data_port_o,
  output logic [15:0] status1_port_o
);
  import scps_pkg::*;

  // resolves a 3?x port from the misc output i/o select bit
  function automatic logic [15:0] resolve_port(input logic color_io, input logic [15:0] mono,
                                               input logic [15:0] color);
    resolve_port = color_io ? color : mono;
  endfunction

  // pin synchronisers
  logic [15:0] addr_s1, addr_s2;
  logic rd_n_s1, rd_n_s2, wr_n_s1, wr_n_s2;
  logic vref_s1, vref_s2, sense_s1, sense_s2;
  logic [15:0] md_s1, md_s2;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_s1 <= 16'h0000;
      addr_s2 <= 16'h0000;
      rd_n_s1 <= 1'b1;
      rd_n_s2 <= 1'b1;
      wr_n_s1 <= 1'b1;
      wr_n_s2 <= 1'b1;
    end else begin
      addr_s1 <= io_addr_i;
      addr_s2 <= addr_s1;
      rd_n_s1 <= io_rd_n_i;
      rd_n_s2 <= rd_n_s1;
      wr_n_s1 <= io_wr_n_i;
      wr_n_s2 <= wr_n_s1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vref_s1 <= 1'b0;
      vref_s2 <= 1'b0;
      sense_s1 <= 1'b0;
      sense_s2 <= 1'b0;
      md_s1 <= 16'h0000;
      md_s2 <= 16'h0000;
    end else begin
      vref_s1 <= vref_grounded_i;
      vref_s2 <= vref_s1;
      sense_s1 <= monitor_sense_input_i;
      sense_s2 <= sense_s1;
      md_s1 <= video_memory_data_lines_i;
      md_s2 <= md_s1;
    end
  end

  // software state
  logic [7:0] misc_out;
  logic [1:0] mode_ctrl;
  logic [3:0] switch_emulation_bit;
  logic display_type_bit;
  logic [3:0] general_strap_bits;
  logic [1:0] panel_select_bits;
  logic [1:0] rom_mapping_bits;
  logic vclk_dir;
  logic bus_mode;
  logic captured;
  logic [1:0] capture_cnt;

  // decode of host palette cycles
  wire rd_cycle = ~rd_n_s2;
  wire wr_cycle = ~wr_n_s2;
  wire hit_read = (addr_s2 == PORT_PEL_MASK) || (addr_s2 == PORT_DAC_WR_ADDR) ||
                  (addr_s2 == PORT_DAC_DATA);
  wire hit_write = (addr_s2 >= PORT_PEL_MASK) && (addr_s2 <= PORT_DAC_DATA);
  wire tft_mode = mode_ctrl[MODE_TFT_BIT] && switch_emulation_bit[3];
  wire ext_dac_mode = vref_s2;
  wire color_io = misc_out[MISC_IO_SEL_BIT];
  // strobes act regardless of which dac is in use
  wire next_rd_strobe_n = tft_mode ? panel_video_bit9_i : ~(rd_cycle && hit_read);
  wire next_wr_strobe_n = ~(wr_cycle && hit_write);
  wire capture_now = !captured && (capture_cnt == CAPTURE_DELAY);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      palette_read_strobe_n_o <= 1'b1;
      palette_write_strobe_n_o <= 1'b1;
    end else begin
      palette_read_strobe_n_o <= next_rd_strobe_n;
      palette_write_strobe_n_o <= next_wr_strobe_n;
    end
  end

  // avalon: one wait state per access, answer on the second cycle
  logic ack;
  logic [31:0] rdata_q;
  wire req = avs_read_i || avs_write_i;
  wire wr_en = avs_write_i && ack && avs_byteenable_i[0];
  wire [7:0] wbyte = avs_writedata_i[7:0];
  wire sel_misc = (avs_address_i == OFF_MISC_OUT);
  wire sel_switch = (avs_address_i == OFF_PANEL_SWITCH);
  wire sel_general = (avs_address_i == OFF_GENERAL_STRAP);
  wire sel_panel = (avs_address_i == OFF_PANEL_SELECT);
  wire sel_rom = (avs_address_i == OFF_ROM_MAPPING);
  wire sel_mode = (avs_address_i == OFF_MODE_CTRL);
  wire sel_stat0 = (avs_address_i == OFF_INPUT_STATUS0);
  wire sel_bstat = (avs_address_i == OFF_BLOCK_STATUS);
  wire sense_bit = ext_dac_mode && sense_s2;
  wire [31:0] rd_switch = {24'h000000, switch_emulation_bit, 4'h0};
  wire [31:0] rd_general = {24'h000000, general_strap_bits, display_type_bit, 3'h0};
  wire [31:0] rd_status0 = {27'h0000000, sense_bit, 4'h0};
  wire [31:0] rd_bstat = {29'h00000000, captured, color_io, ext_dac_mode};
  wire [31:0] next_rdata =
    sel_misc ? {24'h000000, misc_out} :
    sel_switch ? rd_switch :
    sel_general ? rd_general :
    sel_panel ? {30'h00000000, panel_select_bits} :
    sel_rom ? {30'h00000000, rom_mapping_bits} :
    sel_mode ? {30'h00000000, mode_ctrl} :
    sel_stat0 ? rd_status0 :
    sel_bstat ? rd_bstat : READ_ZERO;

  assign avs_waitrequest_o = req && !ack;
  assign avs_readdata_o = rdata_q;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack <= 1'b0;
      rdata_q <= READ_ZERO;
    end else begin
      ack <= req && !ack;
      rdata_q <= (avs_read_i && !ack) ? next_rdata : rdata_q;
    end
  end

  // strap capture once after reset release, once the sync stages hold pin levels
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      capture_cnt <= 2'h0;
      captured <= 1'b0;
    end else begin
      capture_cnt <= (capture_cnt == CAPTURE_DELAY) ? capture_cnt : capture_cnt + 2'h1;
      captured <= captured || capture_now;
    end
  end

  // switch bits: pullup reads one; host may rewrite afterwards
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      switch_emulation_bit <= 4'h0;
      display_type_bit <= 1'b0;
      panel_select_bits <= 2'h0;
    end else if (capture_now) begin
      switch_emulation_bit <= md_s2[MD_SWITCH_HI:MD_SWITCH_LO];
      display_type_bit <= md_s2[MD_DISPLAY_TYPE];
      panel_select_bits <= md_s2[MD_PANEL_SEL_HI:MD_PANEL_SEL_LO];
    end else begin
      switch_emulation_bit <= (wr_en && sel_switch) ? wbyte[7:4] : switch_emulation_bit;
      display_type_bit <= (wr_en && sel_general) ? wbyte[3] : display_type_bit;
      panel_select_bits <= (wr_en && sel_panel) ? wbyte[1:0] : panel_select_bits;
    end
  end

  // pulldown lines are inverted so that a fitted pulldown reads one
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      general_strap_bits <= 4'h0;
      rom_mapping_bits <= 2'h0;
    end else if (capture_now) begin
      general_strap_bits <= ~md_s2[MD_GENERAL_HI:MD_GENERAL_LO];
      rom_mapping_bits <= ~md_s2[MD_ROM_HI:MD_ROM_LO];
    end else begin
      general_strap_bits <= (wr_en && sel_general) ? wbyte[7:4] : general_strap_bits;
      rom_mapping_bits <= (wr_en && sel_rom) ? wbyte[1:0] : rom_mapping_bits;
    end
  end

  // direct straps: no register image, so no software path can change them
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vclk_dir <= 1'b0;
      bus_mode <= 1'b0;
    end else if (capture_now) begin
      vclk_dir <= md_s2[MD_VCLK_DIR];
      bus_mode <= md_s2[MD_BUS_MODE];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      misc_out <= MISC_OUT_RESET;
      mode_ctrl <= MODE_CTRL_RESET;
    end else begin
      misc_out <= (wr_en && sel_misc) ? wbyte : misc_out;
      mode_ctrl <= (wr_en && sel_mode) ? wbyte[1:0] : mode_ctrl;
    end
  end

  // registered pin outputs
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      internal_dac_enable_o <= 1'b1;
      display_type_select_out_o <= 1'b1;
      crt_data_port_o <= PORT_CRT_DATA_MONO;
      status1_port_o <= PORT_STATUS1_MONO;
    end else begin
      internal_dac_enable_o <= !ext_dac_mode;
      display_type_select_out_o <= !mode_ctrl[MODE_LCD_BIT];
      crt_data_port_o <= resolve_port(color_io, PORT_CRT_DATA_MONO, PORT_CRT_DATA_COLOR);
      status1_port_o <= resolve_port(color_io, PORT_STATUS1_MONO, PORT_STATUS1_COLOR);
    end
  end

  assign secondary_video_clock_dir_o = vclk_dir;
  assign host_bus_mode_o = bus_mode;

endmodule // scps_top

// ### tb/scps_dac_model.sv
// external palette dac model that counts strobe pulses
`timescale 1ns/1ps
module scps_dac_model (
  // clock, reset and lcd power-down
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic powered_i,
  // palette strobes
  input wire logic rd_n_i,
  input wire logic wr_n_i
);
  int rd_cnt;
  int wr_cnt;
  logic rd_q;
  logic wr_q;
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_cnt <= 0;
      wr_cnt <= 0;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
    end else begin
      // unpowered in lcd mode, so strobes there are lost
      if (powered_i && rd_q && !rd_n_i) rd_cnt <= rd_cnt + 1;
      if (powered_i && wr_q && !wr_n_i) wr_cnt <= wr_cnt + 1;
      rd_q <= rd_n_i;
      wr_q <= wr_n_i;
    end
  end
endmodule // scps_dac_model

// ### tb/scps_props.sv
// port checker for the strap capture and palette strobe block
`timescale 1ns/1ps
module scps_props (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // inputs watched
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_n_i,
  input wire logic io_wr_n_i,
  input wire logic panel_video_bit9_i,
  input wire logic vref_grounded_i,
  // outputs watched
  input wire logic avs_waitrequest_o,
  input wire logic palette_read_strobe_n_o,
  input wire logic palette_write_strobe_n_o,
  input wire logic internal_dac_enable_o,
  input wire logic [15:0] crt_data_port_o,
  input wire logic [15:0] status1_port_o,
  input wire logic secondary_video_clock_dir_o,
  input wire logic host_bus_mode_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  wire wr_hit = io_addr_i >= 16'h03C6 && io_addr_i <= 16'h03C9;
  wire rd_hit = wr_hit && io_addr_i != 16'h03C7;
  logic [2:0] age;
  // saturating age since reset, straps settle by edge 3
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  a_wr_strobe_hit: assert property ((!io_wr_n_i && wr_hit) [*4] |-> !palette_write_strobe_n_o)
    else $error("write strobe not low");
  a_wr_strobe_idle: assert property (io_wr_n_i [*4] |-> palette_write_strobe_n_o)
    else $error("write strobe low when idle");
  a_rd_strobe_hit: assert property ((!io_rd_n_i && rd_hit && !panel_video_bit9_i) [*4]
    |-> !palette_read_strobe_n_o) else $error("read strobe not low");
  a_rd_strobe_idle: assert property ((io_rd_n_i && panel_video_bit9_i) [*4]
    |-> palette_read_strobe_n_o) else $error("read strobe low when idle");
  a_wait_one: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("wait state count wrong");
  a_ext_dac_mode: assert property (vref_grounded_i [*4] |-> !internal_dac_enable_o)
    else $error("internal dac still on");
  a_port_pair: assert property ((crt_data_port_o == 16'h03B5 && status1_port_o == 16'h03BA)
    || (crt_data_port_o == 16'h03D5 && status1_port_o == 16'h03DA))
    else $error("port letters disagree");
  a_strap_hold: assert property (age == 3'h7 |-> $stable(secondary_video_clock_dir_o)
    && $stable(host_bus_mode_o)) else $error("direct strap changed");
endmodule // scps_props
bind scps_top scps_props u_scps_props (.*);

// ### tb/strap_capture_palette_strobes_bench.sv
// self-checking bench for the strap capture and palette strobe block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("FAIL %0t got %0h exp %0h", $time, g, e); end end
module strap_capture_palette_strobes_bench;
  import scps_pkg::*;
  logic sys_clk_i = 0, resetn_i = 0, avs_read_i = 0, avs_write_i = 0, io_rd_n_i = 1, io_wr_n_i = 1;
  logic panel_video_bit9_i = 1, vref_grounded_i = 0, monitor_sense_input_i = 0;
  logic [4:0] avs_address_i = 0;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [15:0] io_addr_i = 0, video_memory_data_lines_i = 0, md, crt_data_port_o, status1_port_o;
  logic avs_waitrequest_o, palette_read_strobe_n_o, palette_write_strobe_n_o, internal_dac_enable_o;
  logic display_type_select_out_o, secondary_video_clock_dir_o, host_bus_mode_o;
  logic [7:0] model [8];
  int bad_count = 0, num_checks = 0, cyc = 0, n;
  always #20 sys_clk_i = ~sys_clk_i;
  scps_top u_scps_top (.*);
  scps_dac_model u_scps_dac_model (.sys_clk_i, .resetn_i, .powered_i(display_type_select_out_o),
    .rd_n_i(palette_read_strobe_n_o), .wr_n_i(palette_write_strobe_n_o));
  task automatic av(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h0, d};
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (wr) model[a[4:2]] = d;
  endtask
  // address held with the strobe released, so no stray hit
  task automatic io(input logic rd, input logic wr, input logic [15:0] a);
    @(posedge sys_clk_i);
    io_addr_i <= a;
    io_rd_n_i <= !rd;
    io_wr_n_i <= !wr;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    n = $urandom(32'h77C01DDA);
    md = 16'($urandom);
    video_memory_data_lines_i = md;
    repeat (16) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    `CHK({internal_dac_enable_o, display_type_select_out_o}, 2'h3)
    `CHK({crt_data_port_o, status1_port_o}, {PORT_CRT_DATA_MONO, PORT_STATUS1_MONO})
    repeat (4) @(posedge sys_clk_i);
    av(0, OFF_PANEL_SWITCH, 8'h00);
    `CHK(q[7:4], md[15:12])
    av(0, OFF_GENERAL_STRAP, 8'h00);
    `CHK(q[7:3], {~md[7:4], md[11]})
    av(0, OFF_PANEL_SELECT, 8'h00);
    `CHK(q[1:0], md[9:8])
    av(0, OFF_ROM_MAPPING, 8'h00);
    `CHK(q[1:0], ~md[1:0])
    av(0, OFF_BLOCK_STATUS, 8'h00);
    `CHK(q[2], 1'b1)
    video_memory_data_lines_i <= ~md;
    av(1, OFF_PANEL_SELECT, 8'($urandom));
    av(0, OFF_PANEL_SELECT, 8'h00);
    `CHK(q[1:0], model[4][1:0])
    `CHK({secondary_video_clock_dir_o, host_bus_mode_o}, md[3:2])
    for (int a = 16'h03C5; a <= 16'h03CA; a++) begin
      for (int k = 0; k < 2; k++) begin
        io(k == 0, k == 1, 16'(a));
        `CHK(palette_read_strobe_n_o, !(k == 0 && a inside {16'h03C6, 16'h03C8, 16'h03C9}))
        `CHK(palette_write_strobe_n_o, !(k == 1 && a >= 16'h03C6 && a <= 16'h03C9))
        io(0, 0, 16'(a));
      end
    end
    `CHK(u_scps_dac_model.rd_cnt, 3)
    `CHK(u_scps_dac_model.wr_cnt, 4)
    for (int m = 1; m >= 0; m--) begin
      av(1, OFF_MISC_OUT, 8'(m));
      repeat (2) @(posedge sys_clk_i);
      `CHK(crt_data_port_o, m ? PORT_CRT_DATA_COLOR : PORT_CRT_DATA_MONO)
      `CHK(status1_port_o, m ? PORT_STATUS1_COLOR : PORT_STATUS1_MONO)
    end
    // sense held high with the internal dac too, so the gating is tested
    for (int s = 0; s < 3; s++) begin
      vref_grounded_i <= (s < 2);
      monitor_sense_input_i <= (s != 0);
      repeat (4) @(posedge sys_clk_i);
      av(0, OFF_INPUT_STATUS0, 8'h00);
      `CHK(q[STATUS0_SENSE_BIT], s == 1)
      `CHK(internal_dac_enable_o, s == 2)
    end
    av(1, OFF_MODE_CTRL, 8'h01);
    repeat (2) @(posedge sys_clk_i);
    `CHK(display_type_select_out_o, 1'b0)
    av(1, OFF_PANEL_SWITCH, 8'h80);
    av(1, OFF_MODE_CTRL, 8'h02);
    for (int k = 0; k < 2; k++) begin
      panel_video_bit9_i <= k[0];
      repeat (3) @(posedge sys_clk_i);
      `CHK(palette_read_strobe_n_o, k[0])
    end
    `CHK(display_type_select_out_o, 1'b1)
    // second reset recaptures the inverted straps now on the lines
    resetn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    av(0, OFF_PANEL_SELECT, 8'h00);
    `CHK(q[1:0], ~md[9:8])
    av(0, OFF_ROM_MAPPING, 8'h00);
    `CHK(q[1:0], md[1:0])
    `CHK({secondary_video_clock_dir_o, host_bus_mode_o}, ~md[3:2])
    finish_test();
  end
endmodule // strap_capture_palette_strobes_bench
